// >>> shmdp_pkg.sv
// shmdp_pkg: constants and types for the shared memory display port
// assumes a 50 MHz system clock and a slower serial clock from the owner
package shmdp_pkg;
  localparam int LINE_BITS      = 128;          // pixels per line, one bit each
  localparam int LINE_COUNT     = 128;          // lines in the panel
  localparam int ADDR_BITS      = 7;            // line address width
  localparam int SCLK_MAX_KHZ   = 1100;         // fastest serial clock allowed
  localparam int CLK_KHZ        = 50000;        // system clock rate
  localparam int SCLK_MIN_CYC   = (CLK_KHZ + SCLK_MAX_KHZ - 1) / SCLK_MAX_KHZ;
  localparam int FIFO_DEPTH     = 4;            // words between domains
  localparam int COM_TIMEOUT_MS = 1000;         // com pulse watchdog period
  localparam int COM_TIMEOUT_CYC = COM_TIMEOUT_MS * CLK_KHZ;
  localparam logic [7:0] CMD_WRITE = 8'h01;     // mode bit 0: write lines
  localparam logic [7:0] CMD_CLEAR = 8'h04;     // mode bit 2: clear all

  // one received line, as handed across the domain crossing
  typedef struct packed {
    logic                 clear;
    logic [ADDR_BITS-1:0] addr;
    logic [LINE_BITS-1:0] pixels;
  } shmdp_line_t;

  // frame state of the serial receiver
  typedef enum logic [1:0] {
    SHMDP_CMD  = 2'b00,
    SHMDP_ADDR = 2'b01,
    SHMDP_DATA = 2'b10,
    SHMDP_TAIL = 2'b11
  } shmdp_rx_state_t;
endpackage

// >>> shmdp_fifo.sv
// shmdp_fifo: dual clock fifo with gray-coded pointers
// assumes both resets are synchronous to their own clocks
`timescale 1ns/100ps
module shmdp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // write side
  input  wire logic             wclk_i,
  input  wire logic             wreset_i,
  input  wire logic             wvalid_i,
  output logic                  wready_o,
  input  wire logic [WIDTH-1:0] wdata_i,
  // read side
  input  wire logic             rclk_i,
  input  wire logic             reset_i,
  output logic                  rvalid_o,
  input  wire logic             rready_i,
  output logic      [WIDTH-1:0] rdata_o
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 4 || (1 << AW) != DEPTH) $error("depth must be a power of two, at least 4");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wbin_reg;
  logic [AW:0]      wgray_reg;
  logic [AW:0]      rbin_reg;
  logic [AW:0]      rgray_reg;
  logic [AW:0]      rg_s1_reg;
  logic [AW:0]      rg_s2_reg;
  logic [AW:0]      wg_s1_reg;
  logic [AW:0]      wg_s2_reg;
  wire  [AW:0]      wbin_next = wbin_reg + {{AW{1'b0}}, 1'b1};
  wire  [AW:0]      rbin_next = rbin_reg + {{AW{1'b0}}, 1'b1};
  wire  full_w  = wgray_reg == {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]};
  wire  empty_w = rgray_reg == wg_s2_reg;
  wire  push_w  = wvalid_i && !full_w;
  wire  pop_w   = rready_i && !empty_w;

  assign wready_o = !full_w;
  assign rvalid_o = !empty_w;
  assign rdata_o  = mem_reg[rbin_reg[AW-1:0]];

  // write domain: storage and write pointer
  always_ff @(posedge wclk_i) begin
    if (wreset_i) begin
      wbin_reg  <= '0;
      wgray_reg <= '0;
      rg_s1_reg <= '0;
      rg_s2_reg <= '0;
    end else begin
      rg_s1_reg <= rgray_reg;
      rg_s2_reg <= rg_s1_reg;
      if (push_w) begin
        mem_reg[wbin_reg[AW-1:0]] <= wdata_i;
        wbin_reg  <= wbin_next;
        wgray_reg <= wbin_next ^ (wbin_next >> 1);
      end
    end
  end

  // read domain: read pointer
  always_ff @(posedge rclk_i) begin
    if (reset_i) begin
      rbin_reg  <= '0;
      rgray_reg <= '0;
      wg_s1_reg <= '0;
      wg_s2_reg <= '0;
    end else begin
      wg_s1_reg <= wgray_reg;
      wg_s2_reg <= wg_s1_reg;
      if (pop_w) begin
        rbin_reg  <= rbin_next;
        rgray_reg <= rbin_next ^ (rbin_next >> 1);
      end
    end
  end
endmodule

// >>> shmdp_display.sv
// shmdp_display: shared 128x128 memory display, serial write port side
// assumes the owner drives select, serial clock and data; sclk stops between frames
`timescale 1ns/100ps
module shmdp_display
  import shmdp_pkg::*;
#(
  parameter int COM_TIMEOUT = COM_TIMEOUT_CYC
) (
  // system side
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  // ownership and com inversion pins
  input  wire logic                 display_owner_select_i,
  input  wire logic                 com_inversion_pulse_i,
  // target serial link
  input  wire logic                 tgt_serial_clock_i,
  input  wire logic                 tgt_select_i,
  input  wire logic                 tgt_serial_in_i,
  // board controller serial link
  input  wire logic                 ctl_serial_clock_i,
  input  wire logic                 ctl_select_i,
  input  wire logic                 ctl_serial_in_i,
  // pixel readout
  input  wire logic [ADDR_BITS-1:0] read_line_i,
  output logic      [LINE_BITS-1:0] read_pixels_o,
  // status
  output logic                      target_owns_o,
  output logic                      line_written_o,
  output logic                      com_polarity_o,
  output logic                      com_stale_o
);
  initial begin
    if (COM_TIMEOUT < 2) $error("com timeout too short");
  end

  // ownership mux onto the single panel link
  wire owner_w       = display_owner_select_i;
  wire link_clock_w  = owner_w ? tgt_serial_clock_i : ctl_serial_clock_i;
  wire link_select_w = owner_w ? tgt_select_i : ctl_select_i;
  wire link_data_w   = owner_w ? tgt_serial_in_i : ctl_serial_in_i;

  // link domain: frame receiver
  shmdp_rx_state_t      state_reg;
  logic [7:0]           cmd_reg;
  logic [ADDR_BITS-1:0] addr_reg;
  logic [LINE_BITS-1:0] shift_reg;
  logic [7:0]           count_reg;
  logic                 push_reg;
  shmdp_line_t          push_data_reg;
  logic                 fifo_ready_w;
  logic [2:0]           lrst_reg;

  // link reset: system reset crossed, plus idle select clears the frame
  always_ff @(posedge link_clock_w) begin
    lrst_reg <= {lrst_reg[1:0], reset_i};
  end
  wire link_reset_w = lrst_reg[2];

  wire [7:0] count_inc_w = count_reg + 8'h01;
  wire [7:0] cmd_shift_w = {cmd_reg[6:0], link_data_w};
  wire [ADDR_BITS-1:0] addr_shift_w = {addr_reg[ADDR_BITS-2:0], link_data_w};

  // frame decode: field ends and what the command asks for
  wire                 field_end_w  = count_reg == 8'h07;
  wire                 line_end_w   = count_reg == 8'(LINE_BITS - 1);
  wire                 clear_cmd_w  = (cmd_shift_w & CMD_CLEAR) != 8'h00;
  wire                 write_cmd_w  = (cmd_reg & CMD_WRITE) != 8'h00;
  wire [LINE_BITS-1:0] line_shift_w = {shift_reg[LINE_BITS-2:0], link_data_w};

  // frame sequencer; command, address, 128 pixels, 8 tail bits
  // the clock stops between frames, so select low ends a frame at once
  always_ff @(posedge link_clock_w or negedge link_select_w) begin
    if (!link_select_w) begin
      state_reg <= SHMDP_CMD;
      count_reg <= 8'h00;
      push_reg  <= 1'b0;
    end else if (link_reset_w) begin
      state_reg <= SHMDP_CMD;
      count_reg <= 8'h00;
      push_reg  <= 1'b0;
    end else begin
      push_reg  <= 1'b0;
      count_reg <= count_inc_w;
      case (state_reg)
        SHMDP_CMD: begin
          if (field_end_w) begin
            count_reg <= 8'h00;
            push_reg  <= clear_cmd_w && fifo_ready_w;
            state_reg <= clear_cmd_w ? SHMDP_TAIL : SHMDP_ADDR;
          end
        end
        SHMDP_ADDR: begin
          if (field_end_w) begin
            count_reg <= 8'h00;
            state_reg <= SHMDP_DATA;
          end
        end
        SHMDP_DATA: begin
          if (line_end_w) begin
            count_reg <= 8'h00;
            push_reg  <= fifo_ready_w && write_cmd_w;
            state_reg <= SHMDP_TAIL;
          end
        end
        SHMDP_TAIL: begin
          // trailer byte; a further address starts the next line
          if (field_end_w) begin
            count_reg <= 8'h00;
            state_reg <= SHMDP_ADDR;
          end
        end
        default: state_reg <= SHMDP_CMD;
      endcase
    end
  end

  // field shifters and the word handed to the fifo
  always_ff @(posedge link_clock_w) begin
    case (state_reg)
      SHMDP_CMD:  cmd_reg <= cmd_shift_w;
      SHMDP_ADDR: addr_reg <= addr_shift_w;
      SHMDP_DATA: shift_reg <= line_shift_w;
      default:    cmd_reg <= cmd_reg;
    endcase
    if (state_reg == SHMDP_CMD && field_end_w && clear_cmd_w) begin
      push_data_reg <= '{clear: 1'b1, addr: '0, pixels: '0};
    end else if (state_reg == SHMDP_DATA && line_end_w) begin
      push_data_reg <= '{clear: 1'b0, addr: addr_reg, pixels: line_shift_w};
    end
  end

  // line words cross to the system clock
  shmdp_line_t pop_data_w;
  logic        pop_valid_w;
  shmdp_fifo #(
    .WIDTH ($bits(shmdp_line_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .wclk_i   (link_clock_w),
    .wreset_i (link_reset_w),
    .wvalid_i (push_reg),
    .wready_o (fifo_ready_w),
    .wdata_i  (push_data_reg),
    .rclk_i   (clk_i),
    .reset_i  (reset_i),
    .rvalid_o (pop_valid_w),
    .rready_i (1'b1),
    .rdata_o  (pop_data_w)
  );

  // pixel memory, one line of flops per row
  logic [LINE_BITS-1:0] pix_reg [LINE_COUNT];
  genvar gi;
  generate
    for (gi = 0; gi < LINE_COUNT; gi++) begin : g_row
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          pix_reg[gi] <= '0;
        end else if (pop_valid_w && (pop_data_w.clear ||
                     pop_data_w.addr == ADDR_BITS'(gi))) begin
          pix_reg[gi] <= pop_data_w.pixels;
        end
      end
    end
  endgenerate

  // pin synchronisers: three flops, change once stages two and three agree
  logic [2:0] own_sync_reg;
  logic [2:0] com_sync_reg;
  logic       own_reg;
  logic       com_reg;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      own_sync_reg <= 3'h0;
      com_sync_reg <= 3'h0;
      own_reg      <= 1'b0;
      com_reg      <= 1'b0;
    end else begin
      own_sync_reg <= {own_sync_reg[1:0], display_owner_select_i};
      com_sync_reg <= {com_sync_reg[1:0], com_inversion_pulse_i};
      if (own_sync_reg[1] == own_sync_reg[2]) own_reg <= own_sync_reg[2];
      if (com_sync_reg[1] == com_sync_reg[2]) com_reg <= com_sync_reg[2];
    end
  end
  wire com_rise_w = com_sync_reg[1] && com_sync_reg[2] && !com_reg;

  // com polarity toggles per pulse; watchdog flags a missing pulse
  logic [31:0] com_count_reg;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      com_polarity_o <= 1'b0;
      com_count_reg  <= '0;
      com_stale_o    <= 1'b0;
    end else if (com_rise_w) begin
      com_polarity_o <= !com_polarity_o;
      com_count_reg  <= '0;
      com_stale_o    <= 1'b0;
    end else if (com_count_reg == 32'(COM_TIMEOUT - 1)) begin
      com_stale_o <= 1'b1;
    end else begin
      com_count_reg <= com_count_reg + 32'h1;
    end
  end

  // registered status and readout
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      target_owns_o  <= 1'b0;
      line_written_o <= 1'b0;
      read_pixels_o  <= '0;
    end else begin
      target_owns_o  <= own_reg;
      line_written_o <= pop_valid_w;
      read_pixels_o  <= pix_reg[read_line_i];
    end
  end
endmodule

// >>> shmdp_link_model.sv
// shmdp_link_model: behavioural owner of one serial display link
// assumes lclk_i is a free link clock from the bench
`timescale 1ns/100ps
module shmdp_link_model (
  // link clock, free run request
  input  wire logic lclk_i,
  input  wire logic free_i,
  // serial pins
  output logic      sclk_o,
  output logic      sel_o,
  output logic      sdi_o
);
  // clock stands still outside frames, free only around reset
  assign sclk_o = (sel_o | free_i) & lclk_i;
  // bench link rate is time-scaled; a real driver keeps under the pin limit
  initial begin
    sel_o = 1'b0;
    sdi_o = 1'b0;
  end
  // one frame msb first, bits left aligned, changed on falling edge
  task automatic frame(input logic [151:0] fb, input int n);
    for (int i = 151; i > 151 - n; i--) begin
      @(negedge lclk_i);
      sel_o <= 1'b1;
      sdi_o <= fb[i];
    end
    @(negedge lclk_i);
    sel_o <= 1'b0;
    sdi_o <= ~sdi_o; // released line shows no stale bit
  endtask
endmodule

// >>> shmdp_display_sva.sv
// shmdp_display_sva: port checker for the display port
// assumes one system clock domain and synchronous reset
`timescale 1ns/100ps
module shmdp_display_sva
  import shmdp_pkg::*;
#(
  parameter int COM_TIMEOUT = COM_TIMEOUT_CYC
) (
  // watched ports
  input wire logic                 clk_i,
  input wire logic                 reset_i,
  input wire logic                 display_owner_select_i,
  input wire logic                 com_inversion_pulse_i,
  input wire logic [ADDR_BITS-1:0] read_line_i,
  input wire logic [LINE_BITS-1:0] read_pixels_o,
  input wire logic                 target_owns_o,
  input wire logic                 line_written_o,
  input wire logic                 com_polarity_o,
  input wire logic                 com_stale_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // no store and same line asked for a while
  sequence s_quiet;
    ($stable(read_line_i) && !line_written_o) [*8];
  endsequence
  property p_owner_sync;
    $stable(display_owner_select_i) [*6] |-> target_owns_o == display_owner_select_i;
  endproperty
  property p_owner_cause;
    $changed(target_owns_o) |-> target_owns_o == $past(display_owner_select_i);
  endproperty
  property p_written_pulse;
    line_written_o |=> !line_written_o;
  endproperty
  property p_read_hold;
    s_quiet |=> $stable(read_pixels_o);
  endproperty
  property p_pol_toggle;
    $rose(com_inversion_pulse_i) |-> ##[1:6] $changed(com_polarity_o);
  endproperty
  property p_pol_quiet;
    !com_inversion_pulse_i [*8] |=> $stable(com_polarity_o);
  endproperty
  property p_stale_clear;
    $changed(com_polarity_o) |-> ##[0:3] !com_stale_o;
  endproperty
  property p_stale_late;
    $rose(com_stale_o) |-> $past(com_polarity_o, 8) == com_polarity_o;
  endproperty
  a_owner_sync: assert property (p_owner_sync) else $error("owner not followed");
  a_owner_cause: assert property (p_owner_cause) else $error("owner moved alone");
  a_written_pulse: assert property (p_written_pulse) else $error("long store pulse");
  a_read_hold: assert property (p_read_hold) else $error("pixels drifted");
  a_pol_toggle: assert property (p_pol_toggle) else $error("no com toggle");
  a_pol_quiet: assert property (p_pol_quiet) else $error("com toggled alone");
  a_stale_clear: assert property (p_stale_clear) else $error("stale kept");
  a_stale_late: assert property (p_stale_late) else $error("stale too early");
endmodule
bind shmdp_display shmdp_display_sva #(.COM_TIMEOUT(COM_TIMEOUT)) u_shmdp_display_sva (
  .clk_i, .reset_i, .display_owner_select_i, .com_inversion_pulse_i, .read_line_i,
  .read_pixels_o, .target_owns_o, .line_written_o, .com_polarity_o, .com_stale_o);

// >>> tb.sv
// tb: self-checking bench for the shared display port
// assumes two link models and a line memory model in the bench
`timescale 1ns/100ps
module tb;
  import shmdp_pkg::*;
  logic clk = 1'b0, lclk = 1'b0, reset_i = 1'b1, own = 1'b0, com = 1'b0, free = 1'b1;
  logic [6:0] line_sel = 7'h00;
  logic [127:0] read_pixels_o, mdl [128];
  logic t_sclk, t_sel, t_sdi, c_sclk, c_sel, c_sdi, owns, lw, pol, stale;
  int n_fail = 0, n_compared = 0, n_lw = 0, n = 0, a;
  logic [127:0] px;
  logic mpol = 1'b0;
  // system and link clocks, unrelated phase
  always #10 clk = ~clk;
  initial begin
    #7;
    forever #15 lclk = ~lclk;
  end
  shmdp_link_model u_shmdp_link_model_tgt (.lclk_i(lclk), .free_i(free), .sclk_o(t_sclk),
    .sel_o(t_sel), .sdi_o(t_sdi));
  shmdp_link_model u_shmdp_link_model_ctl (.lclk_i(lclk), .free_i(free), .sclk_o(c_sclk),
    .sel_o(c_sel), .sdi_o(c_sdi));
  shmdp_display #(.COM_TIMEOUT(100)) u_shmdp_display (.clk_i(clk), .reset_i(reset_i),
    .display_owner_select_i(own), .com_inversion_pulse_i(com), .tgt_serial_clock_i(t_sclk),
    .tgt_select_i(t_sel), .tgt_serial_in_i(t_sdi), .ctl_serial_clock_i(c_sclk),
    .ctl_select_i(c_sel), .ctl_serial_in_i(c_sdi), .read_line_i(line_sel),
    .read_pixels_o(read_pixels_o), .target_owns_o(owns), .line_written_o(lw),
    .com_polarity_o(pol), .com_stale_o(stale));
  // count store pulses
  always @(posedge clk) if (lw === 1'b1) n_lw <= n_lw + 1;
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one line write, target or controller link
  task automatic wr(input bit tg, input int ad, input logic [127:0] p);
    if (tg) u_shmdp_link_model_tgt.frame({CMD_WRITE, 1'b0, ad[6:0], p, 8'h00}, 152);
    else u_shmdp_link_model_ctl.frame({CMD_WRITE, 1'b0, ad[6:0], p, 8'h00}, 152);
  endtask
  // bounded wait for the expected store count
  task automatic wait_lw(input int k);
    for (int t = 0; t < 400 && n_lw < k; t++) @(posedge clk);
    check(128'(n_lw), 128'(k));
  endtask
  task automatic rd(input int ad);
    @(posedge clk);
    #2 line_sel = ad[6:0];
    repeat (2) @(posedge clk);
    #2;
  endtask
  task automatic pulse;
    #2 com = 1'b1;
    repeat (3) @(posedge clk);
    #2 com = 1'b0;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out;
  end
  initial begin
    void'($urandom(32'h56cb));
    for (int i = 0; i < 128; i++) mdl[i] = 128'h0;
    repeat (2) @(posedge clk);
    #2 reset_i = 1'b0;
    repeat (10) @(posedge clk);
    @(negedge lclk) free = 1'b0;
    rd($urandom % 128);
    check({owns, pol, lw, read_pixels_o[124:0]}, 128'h0);
    #2 own = 1'b1;
    repeat (8) @(posedge clk);
    check(owns, 1'b1);
    // target lines, edge addresses first; target link used only while owning
    for (int k = 0; k < 4; k++) begin
      a = (k == 0) ? 0 : (k == 1) ? 127 : $urandom % 128;
      px = {$urandom, $urandom, $urandom, $urandom};
      wr(1, a, px);
      mdl[a] = px;
      n++;
      wait_lw(n);
      rd(a);
      check(read_pixels_o, mdl[a]);
    end
    // controller ignored and a command without write bit dropped
    wr(0, a, ~px);
    u_shmdp_link_model_tgt.frame({8'h00, 8'h00, px, 8'h00}, 152);
    repeat (60) @(posedge clk);
    check(128'(n_lw), 128'(n));
    rd(a);
    check(read_pixels_o, mdl[a]);
    #2 own = 1'b0;
    repeat (8) @(posedge clk);
    check(owns, 1'b0);
    wr(0, 5, ~px);
    mdl[5] = ~px;
    n++;
    wait_lw(n);
    rd(5);
    check(read_pixels_o, mdl[5]);
    // clear whole panel from the controller
    u_shmdp_link_model_ctl.frame({CMD_CLEAR, 8'h00, 136'h0}, 16);
    for (int i = 0; i < 128; i++) mdl[i] = 128'h0;
    n++;
    wait_lw(n);
    rd(5);
    check(read_pixels_o, mdl[5]);
    rd(a);
    check(read_pixels_o, mdl[a]);
    // com toggles, then goes stale and recovers
    for (int k = 0; k < 3; k++) begin
      pulse;
      mpol = ~mpol;
      check(pol, mpol);
    end
    repeat (110) @(posedge clk);
    check(stale, 1'b1);
    pulse;
    check(stale, 1'b0);
    close_out;
  end
endmodule
